// ---- include/rsc_defines.vh ----
// register offsets, field positions, key codes and timing counts for the reset source controller
// assumes a 10 MHz core clock and an 8-bit register port
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH
`define RSC_CLK_HZ 10000000
`define RSC_ADDR_CAUSE 4'h0
`define RSC_ADDR_SYS3 4'h1
`define RSC_ADDR_KEY 4'h2
`define RSC_ADDR_STATE 4'h3
`define RSC_KEY_CLEAR 8'h71
`define RSC_KEY_PIN 8'hb2
`define RSC_BIT_VDET 0
`define RSC_BIT_WDT 1
`define RSC_BIT_CLK 2
`define RSC_BIT_TRIM 3
`define RSC_BIT_FLASH 4
`define RSC_BIT_TRIM_FAULT_FLAG 5
`define RSC_BIT_CAUSE_CLEAR_REQUEST 6
`define RSC_BIT_RESET_PIN_DISABLE 0
`define RSC_PIN_LOW_NS 5000
`define RSC_PIN_LOW_CYC ((`RSC_PIN_LOW_NS * (`RSC_CLK_HZ / 1000000) + 999) / 1000)
`define RSC_WARMUP_CYC 8192
`define RSC_TRIM_LOAD_CYC 16
`endif

// ---- design/rsc_filter.v ----
// low-level duration filter for the reset pin
// assumes pin level synchronous to the core clock
`timescale 1ns/10ps
module rsc_filter #(
    parameter CYCLES = 50
) (
    input wire clk,
    input wire rst_n,
    input wire enable,
    input wire pin_level,
    output reg pin_reset
);
    reg [15:0] low_count;

    // counts consecutive low cycles; asserts reset once long enough
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_count <= 16'h0000;
            pin_reset <= 1'b0;
        end else if (!enable || pin_level) begin
            low_count <= 16'h0000;
            pin_reset <= 1'b0;
        end else if (low_count >= CYCLES[15:0] - 16'h0001) begin
            pin_reset <= 1'b1;
        end else begin
            low_count <= low_count + 16'h0001;
        end
    end
endmodule // rsc_filter

// ---- design/rsc_reset_ctrl.v ----
// reset source combiner, warm-up sequencer and reset cause tracker
// assumes power-on and fault sources synchronous to CORE_CLK; RSTN is the chip power-on path
`include "rsc_defines.vh"
`timescale 1ns/10ps
module rsc_reset_ctrl #(
    parameter WARMUP_CYC = `RSC_WARMUP_CYC
) (
    // clock and power-on reset
    input wire CORE_CLK,
    input wire RSTN,
    input wire POR_ACTIVE,
    // reset pin shared with port1 bit0
    input wire RESET_PIN_IN,
    // internal factor sources and trim load status
    input wire VDET_EVENT,
    input wire WDT_OVERFLOW,
    input wire CLK_DEADLOCK,
    input wire TRIM_CORRUPT,
    input wire FLASH_STANDBY_ACCESS,
    input wire TRIM_LOAD_OK,
    // register port
    input wire [3:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    // system outputs
    output reg CORE_RESET_N,
    output reg WARMUP_ACTIVE,
    output reg TRIM_LOAD,
    output reg PIN_IS_PORT,
    output reg FETCH_VECTOR
);
    localparam ST_RESET = 2'h0;
    localparam ST_WARM = 2'h1;
    localparam ST_RUN = 2'h2;

    reg [1:0] state;
    reg [15:0] warm_count;
    reg [4:0] cause;
    reg trim_fault;
    reg clear_req;
    reg rst_disable;
    reg pin_func_port;
    reg ext_clear;
    reg [4:0] pending;
    wire pin_reset;
    wire ext_reset;
    wire factor_reset;
    wire [4:0] factor_vec;
    wire key_wr;

    // reset pin filter active only while pin has reset function
    rsc_filter #(
        .CYCLES(`RSC_PIN_LOW_CYC)
    ) u_filter (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .enable(!pin_func_port),
        .pin_level(RESET_PIN_IN),
        .pin_reset(pin_reset)
    );

    assign ext_reset = POR_ACTIVE | pin_reset;
    assign factor_vec = {FLASH_STANDBY_ACCESS, TRIM_CORRUPT, CLK_DEADLOCK, WDT_OVERFLOW, VDET_EVENT};
    assign factor_reset = |factor_vec;
    assign key_wr = REG_WR && (REG_ADDR == `RSC_ADDR_KEY);

    // reset sequencer
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= ST_RESET;
            warm_count <= 16'h0000;
            CORE_RESET_N <= 1'b0;
            WARMUP_ACTIVE <= 1'b0;
            TRIM_LOAD <= 1'b0;
            FETCH_VECTOR <= 1'b0;
            trim_fault <= 1'b0;
        end else if (ext_reset || factor_reset) begin
            state <= ST_RESET;
            warm_count <= 16'h0000;
            CORE_RESET_N <= 1'b0;
            WARMUP_ACTIVE <= 1'b0;
            TRIM_LOAD <= 1'b0;
            FETCH_VECTOR <= 1'b0;
        end else begin
            FETCH_VECTOR <= 1'b0;
            case (state)
                ST_RESET: begin
                    state <= ST_WARM;
                    WARMUP_ACTIVE <= 1'b1;
                    TRIM_LOAD <= 1'b1;
                    warm_count <= 16'h0000;
                end
                ST_WARM: begin
                    warm_count <= warm_count + 16'h0001;
                    if (warm_count == `RSC_TRIM_LOAD_CYC - 1) begin
                        TRIM_LOAD <= 1'b0;
                        trim_fault <= !TRIM_LOAD_OK;
                    end
                    if (warm_count == WARMUP_CYC[15:0] - 16'h0001) begin
                        state <= ST_RUN;
                        WARMUP_ACTIVE <= 1'b0;
                        CORE_RESET_N <= 1'b1;
                        FETCH_VECTOR <= 1'b1;
                    end
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end

    // external or power-on reset marker for cause initialisation
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ext_clear <= 1'b1;
        end else begin
            ext_clear <= ext_reset;
        end
    end

    // cause status, clear request and pin function control
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cause <= 5'h00;
            clear_req <= 1'b0;
            rst_disable <= 1'b0;
            pin_func_port <= 1'b0;
            pending <= 5'h00;
        end else if (ext_clear) begin
            cause <= 5'h00;
            clear_req <= 1'b0;
            rst_disable <= 1'b0;
            pin_func_port <= 1'b0;
            pending <= 5'h00;
        end else begin
            if (factor_reset) begin
                pending <= pending | factor_vec;
            end
            if (state == ST_RUN && |pending) begin
                cause <= pending;
                pending <= factor_vec;
            end else if (key_wr && REG_WDATA == `RSC_KEY_CLEAR && clear_req) begin
                cause <= 5'h00;
            end
            if (key_wr && REG_WDATA == `RSC_KEY_CLEAR && clear_req) begin
                clear_req <= 1'b0;
            end else if (REG_WR && REG_ADDR == `RSC_ADDR_CAUSE) begin
                clear_req <= REG_WDATA[`RSC_BIT_CAUSE_CLEAR_REQUEST];
            end
            if (REG_WR && REG_ADDR == `RSC_ADDR_SYS3) begin
                rst_disable <= REG_WDATA[`RSC_BIT_RESET_PIN_DISABLE];
            end
            if (key_wr && REG_WDATA == `RSC_KEY_PIN && RESET_PIN_IN) begin
                pin_func_port <= rst_disable;
            end
        end
    end

    // read data one cycle after the strobe
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= 8'h00;
            PIN_IS_PORT <= 1'b0;
        end else begin
            PIN_IS_PORT <= pin_func_port;
            REG_RDATA <= 8'h00;
            if (REG_RD) begin
                case (REG_ADDR)
                    `RSC_ADDR_CAUSE: REG_RDATA <= {1'b0, clear_req, trim_fault, cause};
                    `RSC_ADDR_SYS3: REG_RDATA <= {7'h00, rst_disable};
                    `RSC_ADDR_STATE: REG_RDATA <= {5'h00, pin_func_port, state};
                    default: REG_RDATA <= 8'h00;
                endcase
            end
        end
    end
endmodule // rsc_reset_ctrl

// ---- verif/rsc_chk.sv ----
// assertions on the reset source controller ports
// assumes one clock, bound to rsc_reset_ctrl
`timescale 1ns/10ps
module rsc_chk (
    // watched ports
    input wire CORE_CLK, RSTN, POR_ACTIVE, VDET_EVENT, WDT_OVERFLOW, CLK_DEADLOCK, TRIM_CORRUPT,
    input wire FLASH_STANDBY_ACCESS, CORE_RESET_N, WARMUP_ACTIVE, TRIM_LOAD, FETCH_VECTOR
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    a_por_hold: assert property (POR_ACTIVE |=> !CORE_RESET_N && !WARMUP_ACTIVE) else $error("runs in por");
    a_warm_held: assert property (WARMUP_ACTIVE |-> !CORE_RESET_N) else $error("run in warm-up");
    a_run_after: assert property ($rose(CORE_RESET_N) |-> $past(WARMUP_ACTIVE)) else $error("no warm-up");
    a_trim_warm: assert property (TRIM_LOAD |-> WARMUP_ACTIVE) else $error("trim load out of warm-up");
    a_vector_pulse: assert property (FETCH_VECTOR |=> !FETCH_VECTOR) else $error("long fetch");
    a_vdet_reset: assert property (VDET_EVENT |-> ##[1:2] !CORE_RESET_N) else $error("vdet ignored");
    a_wdt_reset: assert property (WDT_OVERFLOW |-> ##[1:2] !CORE_RESET_N) else $error("wdt ignored");
    a_clk_reset: assert property (CLK_DEADLOCK |-> ##[1:2] !CORE_RESET_N) else $error("clk ignored");
    a_trim_reset: assert property (TRIM_CORRUPT |-> ##[1:2] !CORE_RESET_N) else $error("trim ignored");
    a_flash_reset: assert property (FLASH_STANDBY_ACCESS |-> ##[1:2] !CORE_RESET_N) else $error("flash ignored");
endmodule // rsc_chk
bind rsc_reset_ctrl rsc_chk rsc_chk_i (.CORE_CLK, .RSTN, .POR_ACTIVE, .VDET_EVENT, .WDT_OVERFLOW, .CLK_DEADLOCK,
    .TRIM_CORRUPT, .FLASH_STANDBY_ACCESS, .CORE_RESET_N, .WARMUP_ACTIVE, .TRIM_LOAD, .FETCH_VECTOR);

// ---- verif/rsc_pin_model.sv ----
// model of the party on the reset pin
// assumes a pulled-up pin, so released means high
`timescale 1ns/10ps
module rsc_pin_model (
    // clock and pin
    input wire clk,
    output logic pin
);
    initial pin = 1'b1;
    // hold low for n cycles, then release to the pull-up
    task automatic drive_low(input int n);
        @(posedge clk) pin <= 1'b0;
        repeat (n) @(posedge clk);
        pin <= 1'b1;
    endtask
endmodule // rsc_pin_model

// ---- verif/tb.sv ----
// self-checking bench for the reset source controller
// assumes rsc_pin_model on the pin and rsc_chk bound in
`timescale 1ns/10ps
`include "rsc_defines.vh"
module tb;
    localparam int WU = 32;
    logic clk = 0, rstn = 0, por = 1, trim_ok = 1, wr = 0, rd = 0;
    logic [4:0] fault = 0;
    logic [3:0] addr = 0;
    logic [7:0] wdata = 0;
    wire [7:0] rdata;
    wire pin, run_n, warm, tload, port, fetch;
    int num_errors = 0, compares = 0, w, t;
    always #50 clk = ~clk;
    rsc_pin_model rsc_pin_model_i (.clk(clk), .pin(pin));
    rsc_reset_ctrl #(.WARMUP_CYC(WU)) rsc_reset_ctrl_i (.CORE_CLK(clk), .RSTN(rstn), .POR_ACTIVE(por),
        .RESET_PIN_IN(pin), .VDET_EVENT(fault[0]), .WDT_OVERFLOW(fault[1]), .CLK_DEADLOCK(fault[2]),
        .TRIM_CORRUPT(fault[3]), .FLASH_STANDBY_ACCESS(fault[4]), .TRIM_LOAD_OK(trim_ok), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CORE_RESET_N(run_n),
        .WARMUP_ACTIVE(warm), .TRIM_LOAD(tload), .PIN_IS_PORT(port), .FETCH_VECTOR(fetch));
    task automatic chk(input string what, input logic [7:0] exp, got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        @(negedge clk) chk("read data", exp, rdata);
    endtask
    // count warm-up cycles until the core runs
    task automatic wait_run(input string what);
        w = 0;
        t = 0;
        for (int i = 0; i < 300; i++) begin
            @(negedge clk);
            if (warm === 1'b1) w++;
            if (tload === 1'b1) t++;
            if (run_n === 1'b1 && i > 3) break;
        end
        chk(what, 8'(WU), 8'(w));
        chk("trim load cycles", 8'(`RSC_TRIM_LOAD_CYC), 8'(t));
        chk("vector fetch", 8'h01, fetch);
    endtask
    task automatic pulse(input int i);
        @(posedge clk) fault[i] <= 1'b1;
        @(posedge clk) fault[i] <= 1'b0;
        wait_run("factor warm-up");
    endtask
    task automatic t_power_up;
        fork
            rsc_pin_model_i.drive_low(60);
            begin repeat (55) @(posedge clk); por <= 1'b0; end
        join
        wait_run("power-up warm-up");
        rreg(`RSC_ADDR_CAUSE, 8'h00);
    endtask
    task automatic t_pin_reset;
        rsc_pin_model_i.drive_low(40);
        repeat (5) @(negedge clk);
        chk("short low", 8'h01, run_n);
        rsc_pin_model_i.drive_low(55);
        @(negedge clk) chk("long low", 8'h00, run_n);
        wait_run("pin warm-up");
        rreg(`RSC_ADDR_CAUSE, 8'h00);
    endtask
    task automatic t_factors;
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            rreg(`RSC_ADDR_CAUSE, 8'h01 << i);
            wreg(`RSC_ADDR_CAUSE, 8'h40);
            wreg(`RSC_ADDR_KEY, `RSC_KEY_PIN);
            rreg(`RSC_ADDR_CAUSE, 8'h40 | (8'h01 << i));
            wreg(`RSC_ADDR_KEY, `RSC_KEY_CLEAR);
            rreg(`RSC_ADDR_CAUSE, 8'h00);
        end
        @(posedge clk) trim_ok <= 1'b0;
        pulse(2);
        rreg(`RSC_ADDR_CAUSE, 8'h24);
        @(posedge clk) trim_ok <= 1'b1;
        pulse(2);
        rreg(`RSC_ADDR_CAUSE, 8'h04);
    endtask
    task automatic t_port;
        wreg(`RSC_ADDR_SYS3, 8'h01);
        wreg(`RSC_ADDR_KEY, `RSC_KEY_PIN);
        repeat (2) @(negedge clk);
        chk("port mode", 8'h01, port);
        rsc_pin_model_i.drive_low(60);
        @(negedge clk) chk("port low", 8'h01, run_n);
        wreg(`RSC_ADDR_SYS3, 8'h00);
        fork
            rsc_pin_model_i.drive_low(10);
            begin repeat (4) @(posedge clk); wreg(`RSC_ADDR_KEY, `RSC_KEY_PIN); end
        join
        repeat (2) @(negedge clk);
        chk("switch while low", 8'h01, port);
        wreg(`RSC_ADDR_KEY, `RSC_KEY_PIN);
        repeat (2) @(negedge clk);
        chk("reset mode", 8'h00, port);
        rsc_pin_model_i.drive_low(55);
        @(negedge clk) chk("restored low", 8'h00, run_n);
        wait_run("restored warm-up");
    endtask
    // chip reset in mid-run, then warm-up again
    task automatic t_chip_reset;
        @(posedge clk) rstn <= 1'b0;
        @(negedge clk) chk("chip reset run", 8'h00, run_n);
        @(posedge clk) rstn <= 1'b1;
        wait_run("chip reset warm-up");
        rreg(`RSC_ADDR_STATE, 8'h02);
    endtask
    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_power_up();
        t_pin_reset();
        t_factors();
        t_port();
        t_chip_reset();
        report_and_stop();
    end
    initial begin
        #(100 * 20000);
        num_errors++;
        report_and_stop();
    end
endmodule // tb
